// ==== hdl/smh_target.sv ====
`timescale 1ns/1ps
`include "smh_defines.svh"
// Contract
// - Send recovery message right after error status.
// - Recovery message after identify, tag, before command.
// - Rejected recovery message leaves condition unset.
// - Linked completion resets initiator pointers.
// - Restore or reconnect returns pointers to saved.
// - Initiator raises ATN before ACK on bad byte.
// - Parity message without interlock drops BSY.
// - Parity message then message in resends whole.
// - Reject needs interlock, otherwise target rejects it.
// - Target reject goes out before more bytes.
// - ATN after reject returns to first byte out.
// - Pointer modify message adds signed argument.
// - Initiator sends no operation when idle.
// - Queue tag is code byte plus tag.
// - Tagged queuing for logical units, three kinds.
// - Unsupported tag gets reject, process untagged.
// - Tag freed at end, value not ordering.
// - Initiator tag follows identify, one per connection.
// - Reconnect sends simple tag after identify.
// - Initiator aborts an unknown reconnect tag.
// - Head tags go first, stacked last in first.
// - Ordered tags run after all earlier ones.
module smh_target #(
  parameter int QD = 4
) (
  // Clock and reset
  input  wire logic               MCLK,
  input  wire logic               RST,
  // Bus
  smh_bus_if.tgt                  BUS,
  // Connection control
  input  wire logic               SELECTED,
  input  wire logic               FREE,
  // Message to send
  input  wire logic               TX_START,
  input  wire logic [2:0]         TX_LEN,
  input  wire logic [55:0]        TX_DATA,
  // Recovery condition
  input  wire logic               STATUS_ECA,
  input  wire logic               ECA_EN,
  input  wire logic               ECA_CLR,
  output logic                    ECA_ACTIVE,
  // Queue
  input  wire logic               TAG_EN,
  input  wire logic               NEXT_REQ,
  output logic                    NEXT_VALID,
  output logic      [7:0]         NEXT_TAG,
  output smh_pkg::smh_kind_t      NEXT_KIND,
  output logic      [$clog2(QD+1)-1:0] Q_COUNT,
  // Events
  output logic                    CATASTROPHE,
  output logic                    REJECTED,
  output logic                    UNTAGGED,
  output logic                    TAG_ACCEPT,
  output logic                    BUSY
);

  localparam int CW = $clog2(QD + 1);

  smh_pkg::smh_tst_t  state;
  smh_pkg::smh_tst_t  next_state;
  smh_pkg::smh_kind_t rx_kind;
  smh_pkg::smh_kind_t code_kind;
  smh_pkg::smh_kind_t q_kind [QD];
  smh_pkg::smh_kind_t next_q_kind [QD];
  logic [7:0]         q_tag [QD];
  logic [7:0]         next_q_tag [QD];
  logic [CW-1:0]      next_q_cnt;
  logic [7:0]         buf_q [7];
  logic [2:0]         len;
  logic [2:0]         idx;
  logic [7:0]         rx_byte;
  logic               send_rej;
  logic               atn_rel;
  logic               sent_any;
  logic               eca_pend;
  logic               retx;
  logic               routine;
  logic               rx_tag_wait;

  wire       dec        = state == smh_pkg::T_DEC;
  wire       load_eca   = state == smh_pkg::T_IDLE && STATUS_ECA && ECA_EN;
  wire       load_tx    = state == smh_pkg::T_IDLE && TX_START &&
                          TX_LEN != 3'd0;
  wire [7:0] cur_byte   = send_rej ? `SMH_REJECT : buf_q[idx];
  wire       last_in    = send_rej || idx == len - 3'd1;
  wire       in_done    = state == smh_pkg::T_IN_REL && !BUS.ack;
  wire       in_step    = in_done && !last_in;
  wire       in_start   = next_state == smh_pkg::T_IN &&
                          state != smh_pkg::T_IN_REL &&
                          state != smh_pkg::T_IN;
  wire       q_full     = Q_COUNT == CW'(QD);
  wire       code_byte  = !rx_tag_wait;
  wire       is_ident   = code_byte && rx_byte[`SMH_IDENT_BIT];
  wire       is_tag     = code_byte && (rx_byte == `SMH_TAG_SIMPLE ||
                          rx_byte == `SMH_TAG_HEAD ||
                          rx_byte == `SMH_TAG_ORDERED);
  wire       is_perr    = code_byte && rx_byte == `SMH_PARITY_ERR;
  wire       is_rej     = code_byte && rx_byte == `SMH_REJECT;
  wire       is_nop     = code_byte && rx_byte == `SMH_NOP;
  wire       interlock  = sent_any && atn_rel;
  wire       perr_bad   = is_perr && !interlock;
  wire       good_rej   = is_rej && interlock;
  wire       tag_refuse = is_tag && (!TAG_EN || routine || q_full);
  wire       unknown    = code_byte && !is_ident && !is_tag && !is_perr &&
                          !is_rej && !is_nop;
  wire       need_rej   = (is_rej && !interlock) || tag_refuse ||
                          unknown;
  wire       enq        = dec && rx_tag_wait;
  wire       pop        = NEXT_REQ && Q_COUNT != '0 && !enq;
  wire       resend     = dec && next_state == smh_pkg::T_IN && !need_rej;
  wire       in_msg     = state != smh_pkg::T_FREE &&
                          state != smh_pkg::T_IDLE;
  wire       in_dir     = state == smh_pkg::T_IN ||
                          state == smh_pkg::T_IN_REL;

  assign code_kind = (rx_byte == `SMH_TAG_HEAD) ? smh_pkg::KIND_HEAD :
                     (rx_byte == `SMH_TAG_ORDERED) ? smh_pkg::KIND_ORDERED :
                     smh_pkg::KIND_SIMPLE;

  always_comb begin
    next_state = state;
    case (state)
      smh_pkg::T_FREE: begin
        if (SELECTED) begin
          next_state = smh_pkg::T_OUT;
        end
      end
      smh_pkg::T_IDLE: begin
        if (FREE) begin
          next_state = smh_pkg::T_FREE;
        end else if (load_eca || load_tx) begin
          next_state = smh_pkg::T_IN;
        end else if (BUS.atn) begin
          next_state = smh_pkg::T_OUT;
        end
      end
      smh_pkg::T_IN: begin
        if (BUS.ack) begin
          next_state = smh_pkg::T_IN_REL;
        end
      end
      smh_pkg::T_IN_REL: begin
        if (!BUS.ack) begin
          if (!last_in) begin
            next_state = smh_pkg::T_IN;
          end else if (BUS.atn) begin
            next_state = smh_pkg::T_OUT;
          end else begin
            next_state = smh_pkg::T_IDLE;
          end
        end
      end
      smh_pkg::T_OUT: begin
        if (BUS.ack) begin
          next_state = smh_pkg::T_OUT_REL;
        end
      end
      smh_pkg::T_OUT_REL: begin
        if (!BUS.ack) begin
          next_state = smh_pkg::T_DEC;
        end
      end
      smh_pkg::T_DEC: begin
        if (perr_bad) begin
          next_state = smh_pkg::T_FREE;
        end else if (need_rej) begin
          next_state = smh_pkg::T_IN;
        end else if (BUS.atn) begin
          next_state = smh_pkg::T_OUT;
        end else if (retx || is_perr) begin
          next_state = smh_pkg::T_IN;
        end else begin
          next_state = smh_pkg::T_IDLE;
        end
      end
      default: next_state = smh_pkg::T_FREE;
    endcase
  end

  // Head entries are pushed at the front so later ones run first; the
  // process being executed has already left the queue and is untouched.
  always_comb begin
    next_q_tag  = q_tag;
    next_q_kind = q_kind;
    next_q_cnt  = Q_COUNT;
    if (enq) begin
      if (rx_kind == smh_pkg::KIND_HEAD) begin
        for (int i = QD - 1; i > 0; i--) begin
          next_q_tag[i]  = q_tag[i-1];
          next_q_kind[i] = q_kind[i-1];
        end
        next_q_tag[0]  = rx_byte;
        next_q_kind[0] = rx_kind;
      end else begin
        for (int i = 0; i < QD; i++) begin
          if (Q_COUNT == CW'(i)) begin
            next_q_tag[i]  = rx_byte;
            next_q_kind[i] = rx_kind;
          end
        end
      end
      next_q_cnt = Q_COUNT + 1'b1;
    end else if (pop) begin
      for (int i = 0; i < QD - 1; i++) begin
        next_q_tag[i]  = q_tag[i+1];
        next_q_kind[i] = q_kind[i+1];
      end
      next_q_cnt = Q_COUNT - 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state   <= smh_pkg::T_FREE;
      Q_COUNT <= '0;
      for (int i = 0; i < QD; i++) begin
        q_tag[i]  <= `SMH_BYTE_RST;
        q_kind[i] <= smh_pkg::KIND_SIMPLE;
      end
    end else begin
      state   <= next_state;
      Q_COUNT <= next_q_cnt;
      q_tag   <= next_q_tag;
      q_kind  <= next_q_kind;
    end
  end

  // Bus pins.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      BUS.bsy   <= 1'b0;
      BUS.req   <= 1'b0;
      BUS.msg   <= 1'b0;
      BUS.cd    <= 1'b0;
      BUS.io    <= 1'b0;
      BUS.t_db  <= `SMH_BYTE_RST;
      BUS.t_dbp <= `SMH_PAR_RST;
    end else begin
      BUS.bsy   <= next_state != smh_pkg::T_FREE;
      BUS.req   <= state == smh_pkg::T_IN || state == smh_pkg::T_OUT;
      BUS.msg   <= in_msg;
      BUS.cd    <= in_msg;
      BUS.io    <= in_dir;
      BUS.t_db  <= cur_byte;
      BUS.t_dbp <= ~^cur_byte;
    end
  end

  // Outbound buffer is kept intact while a reject is sent, so that a
  // retransmission still has the original message.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      buf_q <= '{default: `SMH_BYTE_RST};
      len   <= 3'd1;
      idx   <= 3'd0;
    end else begin
      if (load_eca) begin
        buf_q[0] <= `SMH_INIT_RECOVERY;
        len      <= 3'd1;
      end else if (load_tx) begin
        for (int i = 0; i < 7; i++) begin
          buf_q[i] <= TX_DATA[8*i +: 8];
        end
        len <= TX_LEN;
      end
      if (in_start) begin
        idx <= 3'd0;
      end else if (in_step) begin
        idx <= idx + 3'd1;
      end
    end
  end

  // Message-out bookkeeping.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_byte     <= `SMH_BYTE_RST;
      send_rej    <= 1'b0;
      atn_rel     <= 1'b0;
      sent_any    <= 1'b0;
      retx        <= 1'b0;
      routine     <= 1'b0;
      rx_tag_wait <= 1'b0;
      rx_kind     <= smh_pkg::KIND_SIMPLE;
    end else begin
      if (state == smh_pkg::T_OUT && BUS.ack) begin
        rx_byte <= BUS.i_db;
      end
      // The reject stays marked after it goes out, so that a parity error
      // reported against it brings back the reject, not the older message.
      if (dec && need_rej) begin
        send_rej <= 1'b1;
      end else if (load_eca || load_tx || state == smh_pkg::T_FREE ||
                   (dec && !is_perr && !retx)) begin
        send_rej <= 1'b0;
      end
      if (in_done) begin
        atn_rel  <= BUS.atn;
        sent_any <= 1'b1;
      end else if (dec || state == smh_pkg::T_FREE) begin
        sent_any <= 1'b0;
      end
      if (resend || state == smh_pkg::T_FREE) begin
        retx <= 1'b0;
      end else if (dec && is_perr && interlock) begin
        retx <= 1'b1;
      end
      if (SELECTED) begin
        routine <= 1'b0;
      end else if (dec && is_ident) begin
        routine <= rx_byte[`SMH_ROUTINE_BIT];
      end
      if (dec) begin
        rx_tag_wait <= is_tag && !tag_refuse;
        rx_kind     <= code_kind;
      end
    end
  end

  // Recovery condition; the enable input is never altered here.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ECA_ACTIVE <= 1'b0;
      eca_pend   <= 1'b0;
    end else begin
      if (ECA_CLR) begin
        ECA_ACTIVE <= 1'b0;
      end
      if (in_done && last_in && !send_rej &&
          cur_byte == `SMH_INIT_RECOVERY) begin
        if (BUS.atn) begin
          eca_pend <= 1'b1;
        end else begin
          ECA_ACTIVE <= 1'b1;
        end
      end else if (dec && good_rej) begin
        eca_pend <= 1'b0;
      end else if (dec && eca_pend && !BUS.atn && !is_perr) begin
        eca_pend   <= 1'b0;
        ECA_ACTIVE <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      NEXT_VALID  <= 1'b0;
      NEXT_TAG    <= `SMH_BYTE_RST;
      NEXT_KIND   <= smh_pkg::KIND_SIMPLE;
      CATASTROPHE <= 1'b0;
      REJECTED    <= 1'b0;
      UNTAGGED    <= 1'b0;
      TAG_ACCEPT  <= 1'b0;
      BUSY        <= 1'b0;
    end else begin
      NEXT_VALID  <= pop;
      if (pop) begin
        NEXT_TAG  <= q_tag[0];
        NEXT_KIND <= q_kind[0];
      end
      CATASTROPHE <= dec && perr_bad;
      REJECTED    <= dec && good_rej;
      UNTAGGED    <= dec && tag_refuse;
      TAG_ACCEPT  <= enq;
      BUSY        <= next_state != smh_pkg::T_IDLE &&
                     next_state != smh_pkg::T_FREE;
    end
  end

endmodule : smh_target

// ==== inc/smh_defines.svh ====
`ifndef SMH_DEFINES_SVH
`define SMH_DEFINES_SVH

// Message codes on the bus.
`define SMH_EXT             8'h01
`define SMH_MDP_LEN         8'h05
`define SMH_MDP_CODE        8'h00
`define SMH_TAG_SIMPLE      8'h20
`define SMH_TAG_HEAD        8'h21
`define SMH_TAG_ORDERED     8'h22
`define SMH_RESTORE_PTRS    8'h03
`define SMH_INIT_RECOVERY   8'h0f
`define SMH_PARITY_ERR      8'h09
`define SMH_REJECT          8'h07
`define SMH_NOP             8'h08
`define SMH_LINKED          8'h0a
`define SMH_LINKED_FLAG     8'h0b
`define SMH_ABORT_TAG       8'h0d

// Field positions in the identify byte.
`define SMH_IDENT_BIT       7
`define SMH_ROUTINE_BIT     5

// Reset values.
`define SMH_BYTE_RST        8'h00
`define SMH_PAR_RST         1'b1

`endif

// ==== inc/smh_pkg.sv ====
package smh_pkg;

  typedef enum logic [1:0] {
    KIND_SIMPLE,
    KIND_HEAD,
    KIND_ORDERED
  } smh_kind_t;

  typedef enum logic [2:0] {
    T_FREE,
    T_IDLE,
    T_IN,
    T_IN_REL,
    T_OUT,
    T_OUT_REL,
    T_DEC
  } smh_tst_t;

endpackage : smh_pkg

// ==== inc/smh_bus_if.sv ====
`timescale 1ns/1ps
interface smh_bus_if;
  logic       bsy;
  logic       req;
  logic       ack;
  logic       atn;
  logic       msg;
  logic       cd;
  logic       io;
  logic [7:0] t_db;
  logic       t_dbp;
  logic [7:0] i_db;
  logic       i_dbp;

  modport tgt (
    output bsy, req, msg, cd, io, t_db, t_dbp,
    input  ack, atn, i_db, i_dbp
  );

  modport ini (
    output ack, atn, i_db, i_dbp,
    input  bsy, req, msg, cd, io, t_db, t_dbp
  );
endinterface : smh_bus_if

// ==== hdl/smh_initiator.sv ====
`timescale 1ns/1ps
`include "smh_defines.svh"
module smh_initiator #(
  parameter int PW = 32
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST,
  // Bus
  smh_bus_if.ini                 BUS,
  // Connection request
  input  wire logic              CONNECT,
  input  wire logic [7:0]        IDENT,
  input  wire logic              TAG_USE,
  input  wire smh_pkg::smh_kind_t TAG_KIND,
  input  wire logic [7:0]        TAG,
  input  wire logic              DONE,
  input  wire logic [7:0]        DONE_TAG,
  // Pointers
  input  wire logic [PW-1:0]     CMD_BASE,
  input  wire logic [PW-1:0]     DATA_BASE,
  input  wire logic [PW-1:0]     STAT_BASE,
  input  wire logic              SAVE_DP,
  output logic      [PW-1:0]     CMD_PTR,
  output logic      [PW-1:0]     DATA_PTR,
  output logic      [PW-1:0]     STAT_PTR,
  // Events
  output logic                   GOT_REJECT,
  output logic                   LINKED,
  output logic                   ABORTED
);

  logic [7:0]    ob [3];
  logic [1:0]    ob_len;
  logic [1:0]    ob_idx;
  logic [2:0]    ri;
  logic          tagw;
  logic [7:0]    ext_len;
  logic [7:0]    ext_code;
  logic [23:0]   arg;
  logic [255:0]  tag_live;
  logic [PW-1:0] saved_dp;
  logic [7:0]    tag_code;

  wire       take     = BUS.req && !BUS.ack;
  wire       rx       = take && BUS.io;
  wire       tx       = take && !BUS.io;
  wire [7:0] b        = BUS.t_db;
  wire       perr     = rx && !(^{b, BUS.t_dbp});
  wire       rx_ok    = rx && !perr;
  wire       first    = rx_ok && ri == 3'd0 && !tagw;
  wire       ext_end  = rx_ok && ri == 3'd6;
  wire       mdp_ok   = ext_len == `SMH_MDP_LEN && ext_code == `SMH_MDP_CODE;
  wire       bad_tag  = rx_ok && tagw && !tag_live[b];
  wire       ext_bad  = ext_end && !mdp_ok;
  wire       linked   = first && (b == `SMH_LINKED || b == `SMH_LINKED_FLAG);
  wire       restore  = first && (b == `SMH_RESTORE_PTRS || b[`SMH_IDENT_BIT]);
  wire       ob_has   = ob_idx < ob_len;
  wire       ob_last  = ob_idx + 2'd1 >= ob_len;
  wire [7:0] tx_byte  = ob_has ? ob[ob_idx] : `SMH_NOP;
  wire [PW-1:0] mdp_arg = PW'($signed({arg, b}));

  assign tag_code = (TAG_KIND == smh_pkg::KIND_HEAD) ? `SMH_TAG_HEAD :
                    (TAG_KIND == smh_pkg::KIND_ORDERED) ? `SMH_TAG_ORDERED :
                    `SMH_TAG_SIMPLE;

  // Handshake: on a bad byte ATN rises on the same edge as ACK, so it is up
  // well before ACK is released for the offending byte.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      BUS.ack   <= 1'b0;
      BUS.atn   <= 1'b0;
      BUS.i_db  <= `SMH_BYTE_RST;
      BUS.i_dbp <= `SMH_PAR_RST;
    end else begin
      if (take) begin
        BUS.ack <= 1'b1;
      end else if (BUS.ack && !BUS.req) begin
        BUS.ack <= 1'b0;
      end
      if (perr || bad_tag || ext_bad || CONNECT) begin
        BUS.atn <= 1'b1;
      end else if (tx && (ob_last || !ob_has)) begin
        BUS.atn <= 1'b0;
      end
      if (tx) begin
        BUS.i_db  <= tx_byte;
        BUS.i_dbp <= ~^tx_byte;
      end
    end
  end

  // Pending outbound message; error answers override a queued one.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ob     <= '{`SMH_BYTE_RST, `SMH_BYTE_RST, `SMH_BYTE_RST};
      ob_len <= 2'd0;
      ob_idx <= 2'd0;
    end else if (perr || bad_tag || ext_bad) begin
      ob[0]  <= perr ? `SMH_PARITY_ERR :
                bad_tag ? `SMH_ABORT_TAG : `SMH_REJECT;
      ob_len <= 2'd1;
      ob_idx <= 2'd0;
    end else if (CONNECT) begin
      ob     <= '{IDENT, tag_code, TAG};
      ob_len <= TAG_USE ? 2'd3 : 2'd1;
      ob_idx <= 2'd0;
    end else if (tx && ob_has) begin
      ob_idx <= ob_last ? 2'd0 : ob_idx + 2'd1;
      if (ob_last) begin
        ob_len <= 2'd0;
      end
    end
  end

  // Inbound message parser.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ri       <= 3'd0;
      tagw     <= 1'b0;
      ext_len  <= 8'h00;
      ext_code <= 8'h00;
      arg      <= 24'h000000;
    end else if (rx_ok) begin
      tagw <= first && b == `SMH_TAG_SIMPLE;
      if (first) begin
        ri <= (b == `SMH_EXT) ? 3'd1 : 3'd0;
      end else if (ri != 3'd0) begin
        ri <= (ri == 3'd6) ? 3'd0 : ri + 3'd1;
      end
      if (ri == 3'd1) begin
        ext_len <= b;
      end
      if (ri == 3'd2) begin
        ext_code <= b;
      end
      if (ri >= 3'd3) begin
        arg <= {arg[15:0], b};
      end
    end
  end

  // Pointer store.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CMD_PTR  <= '0;
      DATA_PTR <= '0;
      STAT_PTR <= '0;
      saved_dp <= '0;
    end else if (linked) begin
      CMD_PTR  <= CMD_BASE;
      DATA_PTR <= DATA_BASE;
      STAT_PTR <= STAT_BASE;
      saved_dp <= DATA_BASE;
    end else if (restore) begin
      CMD_PTR  <= CMD_BASE;
      DATA_PTR <= saved_dp;
      STAT_PTR <= STAT_BASE;
    end else if (ext_end && mdp_ok) begin
      DATA_PTR <= DATA_PTR + mdp_arg;
    end else if (SAVE_DP) begin
      saved_dp <= DATA_PTR;
    end
  end

  // Tags in use; a set in the same cycle as a clear of the same tag wins.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tag_live   <= '0;
      GOT_REJECT <= 1'b0;
      LINKED     <= 1'b0;
      ABORTED    <= 1'b0;
    end else begin
      if (DONE) begin
        tag_live[DONE_TAG] <= 1'b0;
      end
      if (CONNECT && TAG_USE) begin
        tag_live[TAG] <= 1'b1;
      end
      GOT_REJECT <= first && b == `SMH_REJECT;
      LINKED     <= linked;
      ABORTED    <= bad_tag;
    end
  end

endmodule : smh_initiator

// ==== dv/smh_bus_chk_sva.sv ====
`timescale 1ns/1ps
module smh_bus_chk (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RST,
  // Target side
  input wire logic       bsy,
  input wire logic       req,
  input wire logic       msg,
  input wire logic       cd,
  input wire logic       io,
  input wire logic [7:0] t_db,
  input wire logic       t_dbp,
  // Initiator side
  input wire logic       ack,
  input wire logic       atn,
  input wire logic [7:0] i_db,
  input wire logic       i_dbp
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  req_hold_a: assert property (req && !ack |=> req)
    else $error("request dropped before acknowledge");
  ack_answer_a: assert property ($rose(req) |=> ack)
    else $error("acknowledge late");
  req_release_a: assert property ($rose(ack) |-> ##2 !req)
    else $error("request not released after acknowledge");
  ack_release_a: assert property ($fell(req) |=> !ack)
    else $error("acknowledge held after request fell");
  req_gap_a: assert property ($fell(ack) |-> !req ##1 !req)
    else $error("request too soon");
  byte_hold_a: assert property (req && io && $past(req) |-> $stable(t_db))
    else $error("inbound byte changed under request");
  tgt_parity_a: assert property (req && io |-> ^{t_db, t_dbp})
    else $error("inbound byte parity even");
  ini_parity_a: assert property (ack && !io |-> ^{i_db, i_dbp})
    else $error("outbound byte parity even");
  phase_msg_a: assert property (req |-> bsy && msg && cd)
    else $error("request outside message phase");

  cover property ($rose(req) && io);
  cover property ($rose(req) && !io);
  cover property ($rose(atn));
endmodule : smh_bus_chk

// ==== dv/scsi_message_handler_part_tb_top.sv ====
`timescale 1ns/1ps
module scsi_message_handler_part_tb_top;
  logic MCLK, RST, sel, free, txs, seca, eca_en, eca_clr, tag_en, nreq;
  logic conn, tuse, done, sdp, sel2, free2, seca2, d_ack, d_atn;
  logic [2:0] txl;
  logic [55:0] txd;
  logic [7:0] ident, tag, dtag, d_db;
  logic [31:0] cb, db, sb, arg, expd, saved;
  smh_pkg::smh_kind_t kind, nkind;
  wire [31:0] cp, dp, sp;
  wire [7:0] ntag;
  wire [2:0] qc;
  wire nv, tacc, untg, busy, eca, eca2, rej2;
  int fail_count, n_tests, seed, k;
  logic [9:0] q[$];

  smh_bus_if bus ();
  smh_bus_if bus2 ();
  // The second target faces a bench driver that can break the interlock.
  assign bus2.ack = d_ack;
  assign bus2.atn = d_atn;
  assign bus2.i_db = d_db;
  assign bus2.i_dbp = ~^d_db;
  wire [7:0] ev = {rej2, ~bus2.bsy, nv, tacc | untg, ~busy, ~bus2.req,
                   bus2.req & ~bus2.io, bus2.req & bus2.io};

  smh_target #(.QD(4)) i_smh_target (.MCLK(MCLK), .RST(RST), .BUS(bus),
    .SELECTED(sel), .FREE(free), .TX_START(txs), .TX_LEN(txl),
    .TX_DATA(txd), .STATUS_ECA(seca), .ECA_EN(eca_en), .ECA_CLR(eca_clr),
    .ECA_ACTIVE(eca), .TAG_EN(tag_en), .NEXT_REQ(nreq), .NEXT_VALID(nv),
    .NEXT_TAG(ntag), .NEXT_KIND(nkind), .Q_COUNT(qc), .CATASTROPHE(),
    .REJECTED(), .UNTAGGED(untg), .TAG_ACCEPT(tacc), .BUSY(busy));
  smh_target #(.QD(4)) i_smh_target_b (.MCLK(MCLK), .RST(RST), .BUS(bus2),
    .SELECTED(sel2), .FREE(free2), .TX_START(1'b0), .TX_LEN(txl),
    .TX_DATA(txd), .STATUS_ECA(seca2), .ECA_EN(eca_en), .ECA_CLR(eca_clr),
    .ECA_ACTIVE(eca2), .TAG_EN(tag_en), .NEXT_REQ(1'b0), .NEXT_VALID(),
    .NEXT_TAG(), .NEXT_KIND(), .Q_COUNT(), .CATASTROPHE(),
    .REJECTED(rej2), .UNTAGGED(), .TAG_ACCEPT(), .BUSY());
  smh_initiator #(.PW(32)) i_smh_initiator (.MCLK(MCLK), .RST(RST),
    .BUS(bus), .CONNECT(conn), .IDENT(ident), .TAG_USE(tuse),
    .TAG_KIND(kind), .TAG(tag), .DONE(done), .DONE_TAG(dtag),
    .CMD_BASE(cb), .DATA_BASE(db), .STAT_BASE(sb), .SAVE_DP(sdp),
    .CMD_PTR(cp), .DATA_PTR(dp), .STAT_PTR(sp), .GOT_REJECT(),
    .LINKED(), .ABORTED());
  smh_bus_chk i_smh_bus_chk (.MCLK(MCLK), .RST(RST), .bsy(bus.bsy),
    .req(bus.req), .msg(bus.msg), .cd(bus.cd), .io(bus.io),
    .t_db(bus.t_db), .t_dbp(bus.t_dbp), .ack(bus.ack), .atn(bus.atn),
    .i_db(bus.i_db), .i_dbp(bus.i_dbp));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  function automatic logic [55:0] mdp(input logic [31:0] a);
    return {a[7:0], a[15:8], a[23:16], a[31:24], 8'h00, 8'h05, 8'h01};
  endfunction : mdp

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wait_ev(input int b);
    int i;
    for (i = 0; i < 400 && ev[b] !== 1'b1; i++) @(posedge MCLK);
    if (i == 400) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_ev

  task automatic connect(input logic [7:0] id, input int kd,
                         input logic acc, input logic [7:0] t);
    @(posedge MCLK);
    sel <= 1'b1;
    conn <= 1'b1;
    ident <= id;
    kind <= smh_pkg::smh_kind_t'(kd);
    tag <= t;
    @(posedge MCLK);
    sel <= 1'b0;
    conn <= 1'b0;
    wait_ev(4);
    check(tacc, acc);
    if (acc && kd == 1) q.push_front({2'(kd), t});
    else if (acc) q.push_back({2'(kd), t});
    repeat (2) @(posedge MCLK);
    wait_ev(3);
  endtask : connect

  task automatic pulse_free();
    @(posedge MCLK);
    free <= 1'b1;
    free2 <= 1'b1;
    @(posedge MCLK);
    free <= 1'b0;
    free2 <= 1'b0;
  endtask : pulse_free

  task automatic tx(input logic [2:0] l, input logic [55:0] d);
    @(posedge MCLK);
    txs <= 1'b1;
    txl <= l;
    txd <= d;
    @(posedge MCLK);
    txs <= 1'b0;
    repeat (2) @(posedge MCLK);
    wait_ev(3);
  endtask : tx

  task automatic t_out(input logic [7:0] b, input logic a);
    wait_ev(1);
    d_ack <= 1'b1;
    d_db <= b;
    d_atn <= a;
    wait_ev(2);
    d_ack <= 1'b0;
    d_db <= ~b;
  endtask : t_out

  task automatic t_in(input logic [7:0] e, input logic a);
    wait_ev(0);
    check(bus2.t_db, e);
    d_ack <= 1'b1;
    d_atn <= a;
    wait_ev(2);
    d_ack <= 1'b0;
  endtask : t_in

  initial begin
    {sel, free, txs, seca, eca_clr, nreq, conn, done, sdp} = '0;
    {sel2, free2, seca2, d_ack, d_atn, txl, txd, ident, tag, dtag} = '0;
    {eca_en, tag_en, tuse, d_db} = {3'b111, 8'h00};
    kind = smh_pkg::KIND_SIMPLE;
    seed = 32'h3935;
    cb = $random(seed);
    db = $random(seed);
    sb = $random(seed);
    {fail_count, n_tests} = '0;
    RST = 1'b1;
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    connect(8'ha0, 0, 1'b0, 8'h55);
    pulse_free();
    // The fifth tag meets a full queue and must fall back to untagged.
    for (k = 0; k < 5; k++) begin
      connect(8'h80, k % 3, k < 4, {5'($random(seed)), 3'(k)});
      pulse_free();
    end
    check(qc, 3'h4);
    for (k = 0; k < 4; k++) begin
      @(posedge MCLK);
      nreq <= 1'b1;
      done <= 1'b0;
      @(posedge MCLK);
      nreq <= 1'b0;
      wait_ev(5);
      check({nkind, ntag}, q.pop_front());
      done <= 1'b1;
      dtag <= ntag;
    end
    @(posedge MCLK);
    done <= 1'b0;
    tag_en <= 1'b0;
    connect(8'h80, 2, 1'b0, 8'h33);
    for (k = 0; k < 2; k++) begin
      tx(3'h1, 56'h0a + 56'(k));
      check({cp, dp, sp}, {cb, db, sb});
    end
    arg = $random(seed);
    tx(3'h7, mdp(arg));
    expd = db + arg;
    check(dp, expd);
    @(posedge MCLK);
    sdp <= 1'b1;
    @(posedge MCLK);
    sdp <= 1'b0;
    saved = expd;
    arg = $random(seed);
    tx(3'h7, mdp(arg));
    check(dp, expd + arg);
    tx(3'h1, 56'h03);
    check({cp, dp, sp}, {cb, saved, sb});
    @(posedge MCLK);
    seca <= 1'b1;
    @(posedge MCLK);
    seca <= 1'b0;
    repeat (2) @(posedge MCLK);
    wait_ev(3);
    check(eca, 1'b1);
    // A status event with the feature disabled must leave the target idle.
    eca_clr <= 1'b1;
    eca_en <= 1'b0;
    @(posedge MCLK);
    eca_clr <= 1'b0;
    seca <= 1'b1;
    @(posedge MCLK);
    seca <= 1'b0;
    eca_en <= 1'b1;
    repeat (3) @(posedge MCLK);
    check({busy, eca}, 2'b00);
    pulse_free();
    @(posedge MCLK);
    sel2 <= 1'b1;
    @(posedge MCLK);
    sel2 <= 1'b0;
    t_out(8'h80, 1'b0);
    // The target decodes the byte two edges after the release; only then is
    // it idle and willing to take the status event.
    repeat (3) @(posedge MCLK);
    seca2 <= 1'b1;
    @(posedge MCLK);
    seca2 <= 1'b0;
    t_in(8'h0f, 1'b1);
    t_out(8'h07, 1'b0);
    wait_ev(7);
    check(eca2, 1'b0);
    pulse_free();
    sel2 <= 1'b1;
    @(posedge MCLK);
    sel2 <= 1'b0;
    t_out(8'h07, 1'b1);
    t_in(8'h07, 1'b1);
    t_out(8'h09, 1'b0);
    t_in(8'h07, 1'b0);
    pulse_free();
    sel2 <= 1'b1;
    @(posedge MCLK);
    sel2 <= 1'b0;
    t_out(8'h09, 1'b0);
    check(bus2.bsy, 1'b1);
    wait_ev(6);
    stop_test();
  end
endmodule : scsi_message_handler_part_tb_top
